// ===== logic/address_breakpoint_unit.sv
// Address breakpoint unit top: registers, break sequencing, side controls
`timescale 1ns/100ps
module address_breakpoint_unit (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire brk_pkg::cpu_bus_t cpu_bus,
  input wire logic monitor_mode,
  input wire logic wait_mode,
  input wire logic test_high_voltage,
  output brk_pkg::brk_req_t brk_req,
  output logic break_state,
  output logic timer_stop,
  output logic watchdog_hold,
  output logic status_clear_allow,
  output logic irq
);
  logic wr_stb;
  logic rd_stb;
  logic [7:0] reg_addr;
  logic slave_ready;
  logic slave_resp;
  logic enable_reg;
  logic active_reg;
  logic [15:0] break_addr_reg;
  logic armed_reg;
  logic soft_req_reg;
  logic operand_hit_reg;
  logic wait_exit_reg;
  logic clear_en_reg;
  logic [2:0] irq_status_reg;
  logic [2:0] irq_mask_reg;
  logic hit;
  logic match_fire;
  logic [2:0] irq_event;
  brk_pkg::brk_state_t state_reg;
  wire logic [7:0] wdat = hwdata[7:0];

  brk_ahb_slave u_slave (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hreadyout(slave_ready),
    .hresp(slave_resp),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .reg_addr(reg_addr)
  );

  brk_comparator #(.WIDTH(16)) u_cmp (
    .bus_addr(cpu_bus.addr),
    .break_addr(break_addr_reg),
    .hit(hit)
  );

  // Bus response, registered so every output leaves a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= slave_ready;
      hresp <= slave_resp;
    end
  end

  wire logic wr_sc = wr_stb && (reg_addr == brk_pkg::OFS_STATUS_CONTROL);
  wire logic wr_hi = wr_stb && (reg_addr == brk_pkg::OFS_ADDR_HIGH);
  wire logic wr_lo = wr_stb && (reg_addr == brk_pkg::OFS_ADDR_LOW);
  wire logic addr_write = wr_hi || wr_lo;

  // Match when enabled and armed, on a valid bus cycle
  assign match_fire = enable_reg && armed_reg && cpu_bus.valid && hit
    && (state_reg == brk_pkg::BK_IDLE);

  // Enable bit and break address bytes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable_reg <= 1'b0;
      break_addr_reg <= {brk_pkg::RESET_BYTE, brk_pkg::RESET_BYTE};
    end else begin
      if (wr_sc) begin
        enable_reg <= wdat[brk_pkg::BIT_ENABLE];
      end
      if (wr_hi) begin
        break_addr_reg[15:8] <= wdat;
      end
      if (wr_lo) begin
        break_addr_reg[7:0] <= wdat;
      end
    end
  end

  // Active flag: hardware set wins over a software clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      active_reg <= 1'b0;
    end else if (match_fire) begin
      active_reg <= 1'b1;
    end else if (wr_sc) begin
      active_reg <= wdat[brk_pkg::BIT_ACTIVE];
    end
  end

  // Arming: a taken match disarms until the address is rewritten
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      armed_reg <= 1'b1;
    end else if (addr_write) begin
      armed_reg <= 1'b1;
    end else if (match_fire) begin
      armed_reg <= 1'b0;
    end
  end

  // Pending requests: software start and operand matches wait for a boundary
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      soft_req_reg <= 1'b0;
      operand_hit_reg <= 1'b0;
    end else begin
      if (wr_sc && wdat[brk_pkg::BIT_ACTIVE] && !active_reg && state_reg == brk_pkg::BK_IDLE) begin
        soft_req_reg <= 1'b1;
      end else if (state_reg == brk_pkg::BK_ACTIVE) begin
        soft_req_reg <= 1'b0;
      end
      if (match_fire && !cpu_bus.opcode_fetch) begin
        operand_hit_reg <= 1'b1;
      end else if (state_reg == brk_pkg::BK_ACTIVE) begin
        operand_hit_reg <= 1'b0;
      end
    end
  end

  wire logic take_now = (match_fire && cpu_bus.opcode_fetch)
    || ((soft_req_reg || operand_hit_reg) && cpu_bus.instr_boundary);

  // Break sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= brk_pkg::BK_IDLE;
    end else begin
      case (state_reg)
        brk_pkg::BK_IDLE: begin
          if (take_now) begin
            state_reg <= brk_pkg::BK_ACTIVE;
          end else if (match_fire || soft_req_reg) begin
            state_reg <= brk_pkg::BK_PEND;
          end
        end
        brk_pkg::BK_PEND: begin
          if (cpu_bus.instr_boundary) begin
            state_reg <= brk_pkg::BK_ACTIVE;
          end
        end
        brk_pkg::BK_ACTIVE: begin
          if (cpu_bus.rti_done) begin
            state_reg <= brk_pkg::BK_IDLE;
          end
        end
        default: state_reg <= brk_pkg::BK_IDLE;
      endcase
    end
  end

  wire logic entering = (state_reg != brk_pkg::BK_ACTIVE)
    && ((state_reg == brk_pkg::BK_IDLE && take_now) || (state_reg == brk_pkg::BK_PEND && cpu_bus.instr_boundary));

  // Request to system integration logic, and side controls
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      brk_req <= '0;
      break_state <= 1'b0;
      timer_stop <= 1'b0;
      watchdog_hold <= 1'b0;
      status_clear_allow <= 1'b1;
    end else begin
      brk_req.request <= entering;
      brk_req.opcode <= brk_pkg::OPC_SOFT_INT;
      brk_req.vector <= monitor_mode ? brk_pkg::VEC_MONITOR : brk_pkg::VEC_NORMAL;
      break_state <= entering || (state_reg == brk_pkg::BK_ACTIVE && !cpu_bus.rti_done);
      timer_stop <= entering || (state_reg == brk_pkg::BK_ACTIVE && !cpu_bus.rti_done);
      watchdog_hold <= (entering || (state_reg == brk_pkg::BK_ACTIVE && !cpu_bus.rti_done))
        && test_high_voltage;
      status_clear_allow <= !(entering || state_reg == brk_pkg::BK_ACTIVE) || clear_en_reg;
    end
  end

  // Wait-exit flag and flag-clear enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_exit_reg <= 1'b0;
      clear_en_reg <= 1'b0;
    end else begin
      if (entering) begin
        wait_exit_reg <= wait_mode;
      end else if (wr_stb && reg_addr == brk_pkg::OFS_WAIT_EXIT && !wdat[brk_pkg::BIT_WAIT_EXIT]) begin
        wait_exit_reg <= 1'b0;
      end
      if (wr_stb && reg_addr == brk_pkg::OFS_FLAG_CLEAR) begin
        clear_en_reg <= wdat[brk_pkg::BIT_CLEAR_EN];
      end
    end
  end

  // Interrupt status: set wins over write-one-to-clear
  assign irq_event = {state_reg == brk_pkg::BK_ACTIVE && cpu_bus.rti_done,
    entering && soft_req_reg, match_fire};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status_reg <= 3'h0;
      irq_mask_reg <= 3'h0;
      irq <= 1'b0;
    end else begin
      if (wr_stb && reg_addr == brk_pkg::OFS_IRQ_STATUS) begin
        irq_status_reg <= (irq_status_reg & ~wdat[2:0]) | irq_event;
      end else begin
        irq_status_reg <= irq_status_reg | irq_event;
      end
      if (wr_stb && reg_addr == brk_pkg::OFS_IRQ_MASK) begin
        irq_mask_reg <= wdat[2:0];
      end
      irq <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // Read data, registered in the address phase so it stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_stb) begin
      case (haddr[7:0])
        brk_pkg::OFS_STATUS_CONTROL: hrdata <= {24'h000000, enable_reg, active_reg, 6'h00};
        brk_pkg::OFS_ADDR_HIGH: hrdata <= {24'h000000, break_addr_reg[15:8]};
        brk_pkg::OFS_ADDR_LOW: hrdata <= {24'h000000, break_addr_reg[7:0]};
        brk_pkg::OFS_WAIT_EXIT: hrdata <= {30'h0, wait_exit_reg, 1'b0};
        brk_pkg::OFS_FLAG_CLEAR: hrdata <= {24'h000000, clear_en_reg, 7'h00};
        brk_pkg::OFS_IRQ_STATUS: hrdata <= {29'h0, irq_status_reg};
        brk_pkg::OFS_IRQ_MASK: hrdata <= {29'h0, irq_mask_reg};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Checks
  property p_req_on_opcode_match;
    @(posedge hclk) disable iff (!hresetn)
    (match_fire && cpu_bus.opcode_fetch) |=> brk_req.request;
  endproperty
  a_req_on_opcode_match: assert property (p_req_on_opcode_match) else $error("no request after opcode match");
  property p_vector;
    @(posedge hclk) disable iff (!hresetn)
    brk_req.request |-> brk_req.vector == ($past(monitor_mode) ? brk_pkg::VEC_MONITOR : brk_pkg::VEC_NORMAL);
  endproperty
  a_vector: assert property (p_vector) else $error("wrong break vector");
  property p_soft_start;
    @(posedge hclk) disable iff (!hresetn)
    (state_reg == brk_pkg::BK_IDLE && wr_sc && wdat[brk_pkg::BIT_ACTIVE] && !active_reg)
      |=> ##[0:1000] brk_req.request;
  endproperty
  a_soft_start: assert property (p_soft_start) else $error("software break not taken");
  property p_rti_end;
    @(posedge hclk) disable iff (!hresetn)
    (state_reg == brk_pkg::BK_ACTIVE && cpu_bus.rti_done) |=> !break_state && state_reg == brk_pkg::BK_IDLE;
  endproperty
  a_rti_end: assert property (p_rti_end) else $error("break not ended by return");
  property p_no_rearm;
    @(posedge hclk) disable iff (!hresetn)
    (match_fire && !addr_write) |=> !armed_reg;
  endproperty
  a_no_rearm: assert property (p_no_rearm) else $error("break stays armed after match");
  property p_clear_gate;
    @(posedge hclk) disable iff (!hresetn)
    (state_reg == brk_pkg::BK_ACTIVE && $stable(state_reg)) |-> status_clear_allow == $past(clear_en_reg);
  endproperty
  a_clear_gate: assert property (p_clear_gate) else $error("status clear gate wrong in break");
  property p_timers;
    @(posedge hclk) disable iff (!hresetn)
    timer_stop == break_state;
  endproperty
  a_timers: assert property (p_timers) else $error("timers run during break");
  property p_watchdog;
    @(posedge hclk) disable iff (!hresetn)
    watchdog_hold |-> break_state && $past(test_high_voltage);
  endproperty
  a_watchdog: assert property (p_watchdog) else $error("watchdog hold without cause");
  property p_active_set;
    @(posedge hclk) disable iff (!hresetn)
    match_fire |=> active_reg;
  endproperty
  a_active_set: assert property (p_active_set) else $error("active flag not set on match");

  // Sequencing and register checks
  property p_operand_defers;
    @(posedge hclk) disable iff (!hresetn)
    (match_fire && !cpu_bus.opcode_fetch && !soft_req_reg && !operand_hit_reg) |=> !brk_req.request;
  endproperty
  a_operand_defers: assert property (p_operand_defers) else $error("operand match broke too early");
  property p_pend_takes;
    @(posedge hclk) disable iff (!hresetn)
    (state_reg == brk_pkg::BK_PEND && cpu_bus.instr_boundary)
      |=> brk_req.request && state_reg == brk_pkg::BK_ACTIVE;
  endproperty
  a_pend_takes: assert property (p_pend_takes) else $error("pending break not taken at boundary");
  property p_pend_waits;
    @(posedge hclk) disable iff (!hresetn)
    (state_reg == brk_pkg::BK_PEND && !cpu_bus.instr_boundary)
      |=> !brk_req.request && state_reg == brk_pkg::BK_PEND;
  endproperty
  a_pend_waits: assert property (p_pend_waits) else $error("pending break taken off boundary");
  property p_enable_gate;
    @(posedge hclk) disable iff (!hresetn)
    (!enable_reg && !soft_req_reg && !operand_hit_reg && state_reg == brk_pkg::BK_IDLE) |=> !brk_req.request;
  endproperty
  a_enable_gate: assert property (p_enable_gate) else $error("break while disabled");
  property p_addr_high;
    @(posedge hclk) disable iff (!hresetn)
    wr_hi |=> break_addr_reg[15:8] == $past(wdat);
  endproperty
  a_addr_high: assert property (p_addr_high) else $error("address high byte not written");
  property p_addr_low;
    @(posedge hclk) disable iff (!hresetn)
    wr_lo |=> break_addr_reg[7:0] == $past(wdat);
  endproperty
  a_addr_low: assert property (p_addr_low) else $error("address low byte not written");
  property p_wait_capture;
    @(posedge hclk) disable iff (!hresetn)
    entering |=> wait_exit_reg == $past(wait_mode);
  endproperty
  a_wait_capture: assert property (p_wait_capture) else $error("wait exit flag not captured");
  property p_req_pulse;
    @(posedge hclk) disable iff (!hresetn)
    brk_req.request |=> !brk_req.request;
  endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("break request longer than one cycle");
  property p_soft_sets;
    @(posedge hclk) disable iff (!hresetn)
    (wr_sc && wdat[brk_pkg::BIT_ACTIVE]) |=> active_reg;
  endproperty
  a_soft_sets: assert property (p_soft_sets) else $error("active flag not set by software");
  property p_watchdog_on;
    @(posedge hclk) disable iff (!hresetn)
    (state_reg == brk_pkg::BK_ACTIVE && !cpu_bus.rti_done && test_high_voltage) |=> watchdog_hold;
  endproperty
  a_watchdog_on: assert property (p_watchdog_on) else $error("watchdog not held in break");
endmodule // address_breakpoint_unit

// ===== shared/brk_pkg.sv
// Constants, types and register map of the address breakpoint unit
// How it works
// - Enabled break with address bus equal to break address raises a break request.
// - Request makes the core take the interrupt opcode and vector FFFC, FEFC in monitor.
// - Software writing one to the active flag starts a break like a match.
// - Return-from-interrupt inside the break routine ends the break state.
// - Match on an opcode address breaks before that instruction executes.
// - Match on an operand address lets the instruction finish before breaking.
// - Software-started break is taken just before the next instruction begins.
// - A match of an unchanged address after clearing the flag gives no break.
// - In break state, status clears only allowed while the clear enable bit is one.
// - Both timers stop their counters while a break is active.
// - Watchdog held off during break while test high voltage is on reset pin.
// - Enable bit is bit 7, read/write, reset clears it, full 16-bit match.
// - Active flag set by match, reads one, cleared by writing zero or reset.
// - Break address is two byte registers, both cleared by reset.
// - Wait-exit flag reads one when a break ended wait mode, else zero.
package brk_pkg;
  localparam logic [7:0] OFS_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_ADDR_HIGH = 8'h04;
  localparam logic [7:0] OFS_ADDR_LOW = 8'h08;
  localparam logic [7:0] OFS_WAIT_EXIT = 8'h0C;
  localparam logic [7:0] OFS_FLAG_CLEAR = 8'h10;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
  localparam int BIT_ENABLE = 7;
  localparam int BIT_ACTIVE = 6;
  localparam int BIT_WAIT_EXIT = 1;
  localparam int BIT_CLEAR_EN = 7;
  localparam int IRQ_MATCH = 0;
  localparam int IRQ_SOFT = 1;
  localparam int IRQ_END = 2;
  localparam logic [15:0] VEC_NORMAL = 16'hFFFC;
  localparam logic [15:0] VEC_MONITOR = 16'hFEFC;
  localparam logic [7:0] OPC_SOFT_INT = 8'h83;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  typedef enum logic [1:0] {
    BK_IDLE = 2'b00,
    BK_PEND = 2'b01,
    BK_ACTIVE = 2'b10
  } brk_state_t;
  typedef struct packed {
    logic [15:0] addr;
    logic valid;
    logic opcode_fetch;
    logic instr_boundary;
    logic rti_done;
  } cpu_bus_t;
  typedef struct packed {
    logic request;
    logic [7:0] opcode;
    logic [15:0] vector;
  } brk_req_t;
endpackage

// ===== logic/brk_ahb_slave.sv
// AHB-Lite slave front end that turns transfers into one-cycle register strobes
`timescale 1ns/100ps
module brk_ahb_slave (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic wr_stb,
  output logic rd_stb,
  output logic [7:0] reg_addr
);
  logic wr_pend_reg;
  logic [7:0] addr_reg;
  wire logic take = hsel && hready && (htrans == brk_pkg::HTRANS_NONSEQ);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  // Write data arrives in the data phase, so the write strobe trails the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= take && hwrite;
      if (take) begin
        addr_reg <= haddr[7:0];
      end
    end
  end
  assign wr_stb = wr_pend_reg;
  assign rd_stb = take && !hwrite && (hsize != 3'h7);
  assign reg_addr = wr_pend_reg ? addr_reg : haddr[7:0];
endmodule // brk_ahb_slave

// ===== logic/brk_comparator.sv
// Sixteen-bit break address comparator
`timescale 1ns/100ps
module brk_comparator #(
  parameter int WIDTH = 16
) (
  input wire logic [WIDTH-1:0] bus_addr,
  input wire logic [WIDTH-1:0] break_addr,
  output logic hit
);
  logic [WIDTH-1:0] eq;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      assign eq[i] = (bus_addr[i] == break_addr[i]);
    end
  endgenerate
  assign hit = &eq;
endmodule // brk_comparator

// ===== dv/core_model.sv
// Processor core model that walks a small program loop and runs break routines
`timescale 1ns/100ps
module core_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire brk_pkg::brk_req_t brk_req,
  output brk_pkg::cpu_bus_t cpu_bus
);
  logic [15:0] pc_reg;
  logic [1:0] phase_reg;
  logic [7:0] hold_reg;
  logic rti_reg;
  logic fetching;
  // Three-byte instructions in a thirty-byte loop: opcode, two operands
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc_reg <= 16'h1000;
      phase_reg <= 2'h0;
      hold_reg <= 8'h00;
      rti_reg <= 1'b0;
    end else begin
      rti_reg <= (hold_reg == 8'h01);
      if (brk_req.request) begin
        hold_reg <= 8'(30 + ($urandom % 40));
      end else if (hold_reg != 8'h00) begin
        hold_reg <= hold_reg - 8'h01;
      end else begin
        pc_reg <= (pc_reg == 16'h101D) ? 16'h1000 : pc_reg + 16'h0001;
        phase_reg <= (phase_reg == 2'h2) ? 2'h0 : phase_reg + 2'h1;
      end
    end
  end
  // Break routine runs off the loop: no valid cycles, address lines keep moving
  assign fetching = hresetn && (hold_reg == 8'h00);
  assign cpu_bus.valid = fetching;
  assign cpu_bus.addr = fetching ? pc_reg : {hold_reg, ~hold_reg};
  assign cpu_bus.opcode_fetch = fetching && (phase_reg == 2'h0);
  assign cpu_bus.instr_boundary = fetching && (phase_reg == 2'h2);
  assign cpu_bus.rti_done = rti_reg;
endmodule // core_model

// ===== dv/tb.sv
// Self-checking testbench of the address breakpoint unit
`timescale 1ns/100ps
module tb;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, rd_phase;
  logic [31:0] haddr, hwdata, hrdata, rnd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic monitor_mode, wait_mode, test_high_voltage;
  logic break_state, timer_stop, watchdog_hold, status_clear_allow, irq;
  brk_pkg::cpu_bus_t cpu_bus;
  brk_pkg::brk_req_t brk_req;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int since_match = 9;
  int since_bnd = 9;
  logic [31:0] exp_q[$];
  logic [17:0] brk_q[$];
  logic [17:0] ent;
  logic [15:0] bp_addr;
  assign hready = hreadyout;
  address_breakpoint_unit address_breakpoint_unit_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cpu_bus(cpu_bus), .monitor_mode(monitor_mode),
    .wait_mode(wait_mode), .test_high_voltage(test_high_voltage), .brk_req(brk_req),
    .break_state(break_state), .timer_stop(timer_stop), .watchdog_hold(watchdog_hold),
    .status_clear_allow(status_clear_allow), .irq(irq));
  core_model core_model_i (.hclk(hclk), .hresetn(hresetn), .brk_req(brk_req), .cpu_bus(cpu_bus));
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      $display("BAD %s expected %h seen %h", n, e, s);
      err_count++;
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // One single transfer: address phase, then data phase, each held until hready
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= brk_pkg::HTRANS_NONSEQ;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    rd_phase <= !w;
    do @(posedge hclk); while (hready !== 1'b1);
    rd_phase <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask
  task automatic settle;
    repeat (2) @(posedge hclk);
  endtask
  task automatic wait_for(input logic want);
    for (int i = 0; i < 300; i++) begin
      @(posedge hclk);
      if (break_state === want) return;
    end
    chk("break_state wait", {31'h0, want}, {31'h0, break_state});
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_sim;
    end
  end
  // Watcher: read data and break requests against the oldest note
  always @(posedge hclk) begin
    if (rd_phase === 1'b1 && hready === 1'b1) begin
      chk("hrdata", exp_q.pop_front(), hrdata);
      chk("hresp", 32'h0, {31'h0, hresp});
    end
    if (brk_req.request === 1'b1) begin
      if (brk_q.size() == 0) chk("unexpected break", 32'h0, 32'h1);
      else begin
        ent = brk_q.pop_front();
        chk("break vector", {16'h0, ent[15:0]}, {16'h0, brk_req.vector});
        chk("break opcode", {24'h0, brk_pkg::OPC_SOFT_INT}, {24'h0, brk_req.opcode});
        chk("break delay", {31'h0, ent[16]}, ent[17] ? 32'(since_bnd) : 32'(since_match));
      end
    end
    since_match++;
    since_bnd++;
    if (cpu_bus.valid === 1'b1 && cpu_bus.addr === bp_addr) since_match = 0;
    if (cpu_bus.valid === 1'b1 && cpu_bus.instr_boundary === 1'b1) since_bnd = 0;
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    rd_phase = 1'b0;
    monitor_mode = 1'b0;
    wait_mode = 1'b0;
    test_high_voltage = 1'b1;
    bp_addr = 16'h1006;
    rnd = $urandom(78885);
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h0);
    rd(8'h0C, 32'h0);
    wr(8'h04, rnd);
    rd(8'h04, {24'h0, rnd[7:0]});
    wr(8'h40, rnd);
    rd(8'h40, 32'h0);
    // Opcode-address break, then disarm by clearing the flag only
    wr(8'h04, 32'h10);
    wr(8'h08, 32'h06);
    brk_q.push_back({1'b0, 1'b0, brk_pkg::VEC_NORMAL});
    wr(8'h00, 32'h80);
    wait_for(1'b1);
    chk("timer_stop", 32'h1, {31'h0, timer_stop});
    chk("watchdog_hold", 32'h1, {31'h0, watchdog_hold});
    rd(8'h00, 32'hC0);
    wr(8'h10, 32'h00);
    settle;
    chk("status_clear_allow", 32'h0, {31'h0, status_clear_allow});
    wr(8'h10, 32'h80);
    settle;
    chk("status_clear_allow", 32'h1, {31'h0, status_clear_allow});
    wr(8'h00, 32'h80);
    wait_for(1'b0);
    chk("timer_stop", 32'h0, {31'h0, timer_stop});
    repeat (100) @(posedge hclk);
    // Operand-address break after rearming, monitor vector, wait exit
    monitor_mode <= 1'b1;
    wait_mode <= 1'b1;
    test_high_voltage <= 1'b0;
    bp_addr <= 16'h1007;
    brk_q.push_back({1'b0, 1'b1, brk_pkg::VEC_MONITOR});
    wr(8'h08, 32'h07);
    wait_for(1'b1);
    chk("watchdog_hold", 32'h0, {31'h0, watchdog_hold});
    rd(8'h0C, 32'h02);
    wr(8'h00, 32'h00);
    wait_for(1'b0);
    // Software-started break with breaks disabled
    wait_mode <= 1'b0;
    brk_q.push_back({1'b1, 1'b0, brk_pkg::VEC_MONITOR});
    wr(8'h00, 32'h40);
    wait_for(1'b1);
    rd(8'h00, 32'h40);
    rd(8'h0C, 32'h00);
    wr(8'h00, 32'h00);
    wait_for(1'b0);
    // Event status, masking and write-one-to-clear
    rd(8'h14, 32'h07);
    wr(8'h14, 32'h01);
    rd(8'h14, 32'h06);
    wr(8'h18, 32'h00);
    settle;
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(8'h18, 32'h07);
    settle;
    chk("irq unmasked", 32'h1, {31'h0, irq});
    wr(8'h14, 32'h07);
    settle;
    chk("irq", 32'h0, {31'h0, irq});
    rd(8'h14, 32'h00);
    chk("breaks left", 32'h0, 32'(brk_q.size()));
    end_sim;
  end
endmodule // tb
